// File: src/swc_consts.svh
// Register offsets, field positions, reset values and timing constants of the wake config bank.
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
`define SWC_ADDR_W 7
`define SWC_ADDR_BYTE2 7'h31
`define SWC_ADDR_BYTE1 7'h32
`define SWC_ADDR_BYTE0 7'h33
`define SWC_ADDR_FDCFG 7'h34
`define SWC_ADDR_TRIML 7'h38
`define SWC_ADDR_OPT 7'h39
`define SWC_BYTE_RESET 8'h00
`define SWC_FDCFG_RESET 6'h00
`define SWC_RXSEL_RESET 1'h0
`define SWC_TRIM_KEY 2'h3
`define SWC_FD_EN_BIT 0
`define SWC_FILT_LO 1
`define SWC_FILT_HI 3
`define SWC_BYP_BIT 4
`define SWC_ECD_BIT 5
`define SWC_FD_USED_HI 5
`define SWC_OPT_TRIM_HI 4
`define SWC_OPT_RXSEL_BIT 7
`define SWC_FILT_LONG_CODE 3'h7
`define SWC_CLK_NS 50
`define SWC_FILT_STEP_NS 50
`define SWC_FILT_LONG_NS 775
`define SWC_FILT_CNT_W 5
`endif

// File: src/swc_pkg.sv
// Types shared by the wake config bank.
package swc_pkg;
  typedef logic [7:0] swc_byte_t;
  typedef logic [12:0] swc_trim_t;
  typedef logic [2:0] swc_filt_code_t;
endpackage

// File: src/swc_wake_config_regs.sv
// Selective wake configuration register bank with gated oscillator trim.
`timescale 1ns/1ps
`include "swc_consts.svh"

// How it works
// - Three read/write payload compare bytes, bit 0 least significant.
// - Payload bytes clear on power-on or soft reset; restart leaves them untouched.
// - Config bit 0 enables the FD tolerant mode.
// - Filter code picks 50 to 350 ns in 50 ns steps, code 7 gives 775 ns.
// - Bit 4 bypasses only the analog filter; the digital dominant filter stays on.
// - Bit 5 disables the wake error counter, but only with FD tolerant mode on.
// - Silence timeout clears the error counter disable bit in hardware.
// - Config bits 7 and 6 always read zero.
// - Low trim byte is written only when the trim enable field is 11.
// - Trim bits 0 to 4 are the fine, monotonic oscillator trim.
// - Options bits 4 to 0 hold trim bits 12 to 8, gated by trim enable.
// - Options bit 7 picks standard or low-power wake receiver, gated by trim enable.
module swc_wake_config_regs #(
  parameter logic [12:0] TRIM_RESET = 13'h0000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SWC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0] trim_enable,
  input wire logic silence_timeout,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output swc_pkg::swc_byte_t payload_byte_two,
  output swc_pkg::swc_byte_t payload_byte_one,
  output swc_pkg::swc_byte_t payload_byte_zero,
  output logic fd_tolerant_enable,
  output swc_pkg::swc_filt_code_t dominant_filter_time,
  output logic [`SWC_FILT_CNT_W-1:0] dominant_filter_cycles,
  output logic analog_filter_bypass,
  output logic error_counter_disable,
  output logic error_counter_active,
  output swc_pkg::swc_trim_t oscillator_trim,
  output logic wake_receiver_select
);

  // Address decode and the trim key; restart is accepted but forces nothing.
  wire sel_b2 = (reg_addr == `SWC_ADDR_BYTE2);
  wire sel_b1 = (reg_addr == `SWC_ADDR_BYTE1);
  wire sel_b0 = (reg_addr == `SWC_ADDR_BYTE0);
  wire sel_fd = (reg_addr == `SWC_ADDR_FDCFG);
  wire sel_tl = (reg_addr == `SWC_ADDR_TRIML);
  wire sel_op = (reg_addr == `SWC_ADDR_OPT);
  wire trim_open = (trim_enable == `SWC_TRIM_KEY);
  wire wr_b2 = reg_wr && sel_b2;
  wire wr_b1 = reg_wr && sel_b1;
  wire wr_b0 = reg_wr && sel_b0;
  wire wr_fd = reg_wr && sel_fd;
  wire wr_tl = reg_wr && sel_tl && trim_open;
  wire wr_op = reg_wr && sel_op && trim_open;
  wire restart_seen = restart;

  // Register reset is the synchronous rst_b or the soft reset pulse.
  wire clr = !rst_b || soft_reset;

  // Payload compare bytes; restart deliberately keeps whatever was there.
  always_ff @(posedge mclk) begin
    if (clr) begin
      payload_byte_two <= `SWC_BYTE_RESET;
      payload_byte_one <= `SWC_BYTE_RESET;
      payload_byte_zero <= `SWC_BYTE_RESET;
    end else begin
      if (wr_b2) payload_byte_two <= reg_wdata;
      if (wr_b1) payload_byte_one <= reg_wdata;
      if (wr_b0) payload_byte_zero <= reg_wdata;
    end
  end

  // FD config fields; the silence timeout beats a same-cycle software write.
  wire [`SWC_FD_USED_HI:0] fd_wr_bits = reg_wdata[`SWC_FD_USED_HI:0];
  wire next_ecd = silence_timeout ? 1'b0 :
      (wr_fd ? fd_wr_bits[`SWC_ECD_BIT] : error_counter_disable);
  always_ff @(posedge mclk) begin
    if (clr) begin
      {error_counter_disable, analog_filter_bypass, dominant_filter_time,
       fd_tolerant_enable} <= `SWC_FDCFG_RESET;
    end else begin
      error_counter_disable <= next_ecd;
      if (wr_fd) begin
        fd_tolerant_enable <= fd_wr_bits[`SWC_FD_EN_BIT];
        dominant_filter_time <= fd_wr_bits[`SWC_FILT_HI:`SWC_FILT_LO];
        analog_filter_bypass <= fd_wr_bits[`SWC_BYP_BIT];
      end
    end
  end

  // Counter runs unless disabled and FD tolerant mode is on.
  always_ff @(posedge mclk) begin
    if (clr) error_counter_active <= 1'b1;
    else error_counter_active <= !(error_counter_disable && fd_tolerant_enable);
  end

  // Filter time in cycles, rounded up; the digital filter ignores the bypass bit.
  wire [31:0] filt_ns = (dominant_filter_time == `SWC_FILT_LONG_CODE) ? `SWC_FILT_LONG_NS :
      (32'(dominant_filter_time) + 32'd1) * `SWC_FILT_STEP_NS;
  wire [31:0] filt_cyc = (filt_ns + `SWC_CLK_NS - 1) / `SWC_CLK_NS;
  always_ff @(posedge mclk) begin
    if (!rst_b) dominant_filter_cycles <= '0;
    else dominant_filter_cycles <= filt_cyc[`SWC_FILT_CNT_W-1:0];
  end

  // Trim is not cleared by soft reset; its power-on value is a parameter.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      oscillator_trim <= TRIM_RESET;
      wake_receiver_select <= `SWC_RXSEL_RESET;
    end else begin
      if (wr_tl) oscillator_trim[7:0] <= reg_wdata;
      if (wr_op) begin
        oscillator_trim[12:8] <= reg_wdata[`SWC_OPT_TRIM_HI:0];
        wake_receiver_select <= reg_wdata[`SWC_OPT_RXSEL_BIT];
      end
    end
  end

  // Read data; reserved and unmapped bits return zero.
  wire [7:0] rd_fd = {2'b00, error_counter_disable, analog_filter_bypass,
                      dominant_filter_time, fd_tolerant_enable};
  wire rx_vis = wake_receiver_select && trim_open;
  wire [7:0] rd_op = {rx_vis, 2'b00, oscillator_trim[12:8]};
  wire [7:0] rd_mux = sel_b2 ? payload_byte_two :
                      sel_b1 ? payload_byte_one :
                      sel_b0 ? payload_byte_zero :
                      sel_fd ? rd_fd :
                      sel_tl ? oscillator_trim[7:0] :
                      sel_op ? rd_op : 8'h00;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  // Checks next to the logic above.
  sequence s_locked_trim_write;
    reg_wr && sel_tl && !trim_open;
  endsequence
  property p_payload_write;
    @(posedge mclk) disable iff (!rst_b) (reg_wr && sel_b2 && !soft_reset) |=>
      payload_byte_two == $past(reg_wdata);
  endproperty
  a_payload_write: assert property (p_payload_write) else $error("payload write lost");
  property p_soft_clear;
    @(posedge mclk) disable iff (!rst_b) soft_reset |=>
      payload_byte_zero == 8'h00 && !fd_tolerant_enable;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset did not clear");
  property p_restart_hold;
    @(posedge mclk) disable iff (!rst_b) (restart_seen && !soft_reset && !reg_wr) |=>
      $stable(payload_byte_one);
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart changed byte");
  property p_fd_en;
    @(posedge mclk) disable iff (!rst_b) (wr_fd && !soft_reset) |=>
      fd_tolerant_enable == $past(reg_wdata[0]);
  endproperty
  a_fd_en: assert property (p_fd_en) else $error("fd enable wrong");
  property p_filter_long;
    @(posedge mclk) disable iff (!rst_b) (dominant_filter_time == `SWC_FILT_LONG_CODE) |=>
      dominant_filter_cycles == 5'h10;
  endproperty
  a_filter_long: assert property (p_filter_long) else $error("long filter count wrong");
  property p_err_cnt;
    @(posedge mclk) disable iff (!rst_b || soft_reset)
      (error_counter_disable && !fd_tolerant_enable) |=> error_counter_active;
  endproperty
  a_err_cnt: assert property (p_err_cnt) else $error("counter disabled without fd");
  property p_silence;
    @(posedge mclk) disable iff (!rst_b) silence_timeout |=> !error_counter_disable;
  endproperty
  a_silence: assert property (p_silence) else $error("timeout did not clear bit");
  property p_fd_reserved;
    @(posedge mclk) disable iff (!rst_b) (reg_rd && sel_fd) |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_fd_reserved: assert property (p_fd_reserved) else $error("reserved bits nonzero");
  property p_trim_locked;
    @(posedge mclk) disable iff (!rst_b) s_locked_trim_write |=> $stable(oscillator_trim[7:0]);
  endproperty
  a_trim_locked: assert property (p_trim_locked) else $error("locked trim changed");
  property p_opt_locked;
    @(posedge mclk) disable iff (!rst_b) (reg_wr && sel_op && !trim_open) |=>
      $stable(oscillator_trim[12:8]) && $stable(wake_receiver_select);
  endproperty
  a_opt_locked: assert property (p_opt_locked) else $error("locked options changed");
  property p_opt_write;
    @(posedge mclk) disable iff (!rst_b) wr_op |=>
      oscillator_trim[12:8] == $past(reg_wdata[4:0]) &&
      wake_receiver_select == $past(reg_wdata[7]);
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("options lost");

  // The disable must really stop the counter once FD tolerant mode is on.
  property p_err_off;
    @(posedge mclk) disable iff (!rst_b || soft_reset)
      (error_counter_disable && fd_tolerant_enable) |=> !error_counter_active;
  endproperty
  a_err_off: assert property (p_err_off) else $error("counter still active");
  // An opened low trim write must land whole.
  property p_trim_write;
    @(posedge mclk) disable iff (!rst_b) wr_tl |=> oscillator_trim[7:0] == $past(reg_wdata);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");
  // Filter code and bypass land independently of each other.
  property p_fd_fields;
    @(posedge mclk) disable iff (!rst_b) (wr_fd && !soft_reset) |=>
      dominant_filter_time == $past(reg_wdata[`SWC_FILT_HI:`SWC_FILT_LO]) &&
      analog_filter_bypass == $past(reg_wdata[`SWC_BYP_BIT]);
  endproperty
  a_fd_fields: assert property (p_fd_fields) else $error("fd fields wrong");
  // Without the key the receiver choice must not leak out on a read.
  property p_rx_hidden;
    @(posedge mclk) disable iff (!rst_b) (reg_rd && sel_op && !trim_open) |=> !reg_rdata[7];
  endproperty
  a_rx_hidden: assert property (p_rx_hidden) else $error("receiver bit visible");
endmodule

// File: tb/swc_host_model.sv
// Host model that issues register writes and reads into the wake config bank.
`timescale 1ns/1ps
module swc_host_model (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] trim_enable
);
  // Idle values from time zero: strobes low and the trim key closed.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    trim_enable = 2'h0;
  end
  // The key is a level, changed off the sampling edge.
  task automatic key(input logic [1:0] k);
    @(negedge mclk);
    trim_enable = k;
  endtask
  // Released lines show the inverse, so stale values are never mistaken for live ones.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Read data is only taken while the valid pulse stands.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
  // The receiver choice always carries the coarse trim back unchanged.
  task automatic pick_rx(input logic sel, input logic [4:0] keep_hi);
    wr(7'h39, {sel, 2'b00, keep_hi});
  endtask
  // Only the fine trim moves; the temperature bits are written back as they were.
  task automatic trim_fine(input logic [4:0] f, input logic [2:0] keep);
    wr(7'h38, {keep, f});
  endtask
endmodule

// File: tb/selective_wake_config_regs_tb.sv
// Self-checking bench for the wake config bank.
`timescale 1ns/1ps
module selective_wake_config_regs_tb;
  typedef struct packed {logic [6:0] a; logic [7:0] d; logic [1:0] k; logic [7:0] q;} swc_row_t;
  logic mclk, rst_b, soft_reset, restart, silence_timeout, reg_wr, reg_rd, reg_rvalid;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic [1:0] trim_enable;
  logic fd_tolerant_enable, analog_filter_bypass, error_counter_disable;
  logic error_counter_active, wake_receiver_select;
  logic [4:0] dominant_filter_cycles;
  swc_pkg::swc_byte_t payload_byte_two, payload_byte_one, payload_byte_zero;
  swc_pkg::swc_filt_code_t dominant_filter_time;
  swc_pkg::swc_trim_t oscillator_trim;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  // Address, data, trim key and expected readback; keyless gated rows must be refused.
  swc_row_t rows [10] = '{'{7'h31, 8'ha5, 2'h0, 8'ha5}, '{7'h32, 8'h5a, 2'h0, 8'h5a},
    '{7'h33, 8'h81, 2'h0, 8'h81}, '{7'h34, 8'hff, 2'h0, 8'h3f}, '{7'h38, 8'h1b, 2'h3, 8'h1b},
    '{7'h39, 8'he0, 2'h3, 8'h80}, '{7'h39, 8'h95, 2'h3, 8'h95}, '{7'h38, 8'h00, 2'h1, 8'h1b},
    '{7'h39, 8'h00, 2'h2, 8'h15}, '{7'h3a, 8'hff, 2'h3, 8'h00}};
  swc_host_model host (.mclk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .trim_enable);
  swc_wake_config_regs uut (.mclk, .rst_b, .soft_reset, .restart, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .trim_enable, .silence_timeout, .reg_rdata, .reg_rvalid, .payload_byte_two,
    .payload_byte_one, .payload_byte_zero, .fd_tolerant_enable, .dominant_filter_time,
    .dominant_filter_cycles, .analog_filter_bypass, .error_counter_disable,
    .error_counter_active, .oscillator_trim, .wake_receiver_select);
  // Case equality, so an unknown never passes for a match.
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Clock of 50 ns period.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // The whole run needs about 125 cycles; the ceiling of 2000 leaves wide margin for a hang.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Table first, then filter codes, timeout, restart, soft reset and a second hard reset.
  initial begin
    rst_b = 1'b0;
    soft_reset = 1'b0;
    restart = 1'b0;
    silence_timeout = 1'b0;
    // Counting rising edges keeps the hold at 20 cycles whatever order time zero runs in.
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    check("por", {payload_byte_two, payload_byte_zero, fd_tolerant_enable, error_counter_active},
      18'h00001);
    foreach (rows[i]) begin
      host.key(rows[i].k);
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, got);
      check("readback", got, rows[i].q);
    end
    check("payload", {payload_byte_two, payload_byte_one, payload_byte_zero}, 24'ha55a81);
    check("trim", oscillator_trim, 13'h151b);
    host.trim_fine(5'h1f, 3'h0);
    host.pick_rx(1'b0, 5'h15);
    check("trim rx", {wake_receiver_select, oscillator_trim}, 14'h151f);
    host.pick_rx(1'b1, 5'h15);
    for (int c = 0; c < 8; c++) begin
      host.wr(7'h34, {3'h1, 1'b0, c[2:0], 1'b0});
      host.rd(7'h34, got);
      check("filter", {error_counter_active, dominant_filter_cycles},
        (c < 7) ? 16'(c + 33) : 16'h0030);
      check("filter code", {got, error_counter_disable, dominant_filter_time},
        {3'h1, 1'b0, c[2:0], 1'b0, 1'b1, c[2:0]});
    end
    host.wr(7'h34, 8'h3f);
    host.rd(7'h34, got);
    check("fd cfg", {fd_tolerant_enable, analog_filter_bypass, error_counter_active,
      dominant_filter_cycles}, 8'hd0);
    @(negedge mclk);
    silence_timeout = 1'b1;
    @(negedge mclk);
    silence_timeout = 1'b0;
    host.rd(7'h34, got);
    check("timeout", {error_counter_active, got}, 9'h11f);
    @(negedge mclk);
    restart = 1'b1;
    @(negedge mclk);
    restart = 1'b0;
    check("restart", payload_byte_zero, 8'h81);
    @(negedge mclk);
    soft_reset = 1'b1;
    @(negedge mclk);
    soft_reset = 1'b0;
    host.rd(7'h34, got);
    check("soft", {payload_byte_two, payload_byte_one, payload_byte_zero} | got, 24'h0);
    check("trim kept", oscillator_trim, 13'h151f);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    check("reset", {wake_receiver_select, oscillator_trim, error_counter_active}, 15'h0001);
    give_verdict();
  end
endmodule
